// File: logic/adc_sample_buffer_status.v
/*
  Acquisition control: start/stop, trigger wait, sample buffer in FIFO
  or ring form, status flags, counters and buffer reads over a simple
  register port. Assumes a converter that pulses convDone with data,
  a sampling tick and trigger from pins, and host on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adc_acq_defines.vh"

// How it works
// - Start command begins sampling; stop command halts it at any time.
// - Status and buffer reads work while sampling continues.
// - Operating flag set from start until done, error or stop.
// - Trigger or level start sets waiting flag until trigger arrives.
// - Waiting flag sets again on every re-entry in repeat mode with trigger or level start.
// - Threshold flag sets when stored count reaches programmed count.
// - FIFO: threshold flag clears when reads drop count below threshold.
// - Ring: threshold flag stays set until reset or memory reset.
// - Writing into full buffer sets overflow; FIFO then stops.
// - Ring overflow keeps converting and overwrites oldest data.
// - Sampling period shorter than conversion time sets clock error.
// - Running too long without conversion sets conversion error, stops.
// - Stored sample count readable, only in device buffer mode.
// - Current repeat count readable.
// - FIFO read returns oldest sample and frees its space.
// - Ring read counts back from write position, keeps data.
// - Samples are 16-bit offset binary, 32768 means 0 V.
// - Status reset clears clock error and conversion error.
// - Memory reset, only in device buffer mode, clears buffer pointers, overflow, threshold, count; repeat only if no stop, error or repeat end that cycle.
// - Any error stops sampling whatever stop condition is set.
module adc_sample_buffer_status #(
  parameter WDOG_CYCLES = `WDOG_CYC
) (
  input wire clk, // 40 MHz clock
  input wire rst, // Synchronous reset, high
  input wire [`ADDR_W-1:0] addr, // Register word address
  input wire [15:0] wrData, // Write data
  input wire wrStb, // Write strobe
  input wire rdStb, // Read strobe
  output reg [15:0] rdData, // Read data, cycle after strobe
  input wire sampleTickPin, // Sampling clock edge source (pin)
  input wire trigPin, // External start trigger (pin)
  input wire levelHit, // Level comparison met, same clock
  input wire convDone, // Conversion done pulse, same clock
  input wire [`DATA_W-1:0] convData, // Converted sample, offset binary
  output reg convStart, // Starts one conversion, pulse
  output reg [5:0] status // Status flags
);

  localparam S_IDLE = 2'h0;
  localparam S_WAIT = 2'h1;
  localparam S_RUN = 2'h2;

  reg [1:0] state;
  reg [15:0] ctrl;
  reg [`CNT_W-1:0] thresh;
  reg [15:0] repLimit;
  reg [15:0] repCount;
  reg [`CNT_W-1:0] backCnt;
  reg [`DATA_W-1:0] mem [0:`BUF_DEPTH-1];
  reg [`BUF_AW-1:0] wrPtr;
  reg [`BUF_AW-1:0] rdPtr;
  reg [`CNT_W-1:0] count;
  reg tickS1, tickS2, tickS3;
  reg trigS1, trigS2, trigS3;
  reg [15:0] periodCnt;
  reg [17:0] wdogCnt;
  reg busy;
  reg [15:0] next_rdData;

  wire ringMode = ctrl[`CTRL_RING];
  wire [1:0] startSel = ctrl[`CTRL_START_HI:`CTRL_START_LO];
  wire devBuf = ctrl[`CTRL_DEVBUF];
  wire cmdWr = wrStb && (addr == `REG_CMD);
  wire cmdStart = cmdWr && wrData[`CMD_START];
  wire cmdStop = cmdWr && wrData[`CMD_STOP];
  wire cmdStatClr = cmdWr && wrData[`CMD_STATCLR];
  wire cmdMemClr = cmdWr && wrData[`CMD_MEMCLR] && devBuf;
  wire tickEdge = tickS2 && !tickS3;
  wire trigEdge = trigS2 && !trigS3;
  wire full = (count == `BUF_DEPTH);
  wire empty = (count == {`CNT_W{1'b0}});
  wire dataRd = rdStb && (addr == `REG_DATA);
  wire fifoPop = dataRd && !ringMode && !empty;
  wire writeEn = convDone && (state == S_RUN);
  wire overflowEv = writeEn && full && !fifoPop;
  wire storeEn = writeEn && (!full || ringMode || fifoPop);
  wire clkErrEv = (state == S_RUN) && tickEdge && busy
    && (periodCnt < `CONV_MIN_CYC);
  wire convErrEv = (state != S_IDLE) && (wdogCnt >= WDOG_CYCLES - 1);
  wire fifoStop = overflowEv && !ringMode;
  wire errStop = clkErrEv || convErrEv || fifoStop;
  wire startMet = (startSel == `START_TRIG) ? trigEdge
    : (startSel == `START_LEVEL) ? levelHit : 1'b1;
  // Each stored sample closes one repetition when a limit is set
  wire repeatEnd = writeEn && (repLimit != 16'h0000);
  wire [`CNT_W-1:0] nextCount = count + {{(`CNT_W-1){1'b0}}, storeEn && (!full || fifoPop)}
    - {{(`CNT_W-1){1'b0}}, fifoPop};
  wire [`CNT_W-1:0] countAfter = cmdMemClr ? {`CNT_W{1'b0}} : nextCount;
  wire [`BUF_AW-1:0] backAddr = wrPtr - backCnt[`BUF_AW-1:0];

  // Pin synchronisers
  always @(posedge clk)
  begin
    tickS1 <= sampleTickPin;
    tickS2 <= tickS1;
    tickS3 <= tickS2;
    trigS1 <= trigPin;
    trigS2 <= trigS1;
    trigS3 <= trigS2;
  end

  // Configuration registers
  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= `CTRL_RESET;
      thresh <= {`CNT_W{1'b0}};
      repLimit <= 16'h0000;
      backCnt <= {`CNT_W{1'b0}};
    end
    else if (wrStb)
    begin
      case (addr)
        `REG_CTRL: ctrl <= wrData;
        `REG_THRESH: thresh <= wrData[`CNT_W-1:0];
        `REG_REPLIM: repLimit <= wrData;
        `REG_BACK: backCnt <= wrData[`CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // Run control
  always @(posedge clk)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      repCount <= 16'h0000;
    end
    else if (cmdStop || errStop)
    begin
      state <= S_IDLE;
    end
    else
    begin
      if (cmdMemClr)
        repCount <= 16'h0000;
      case (state)
        S_IDLE:
          if (cmdStart)
            state <= (startSel == `START_SW) ? S_RUN : S_WAIT;
        S_WAIT:
          if (startMet)
            state <= S_RUN;
        S_RUN:
          if (repeatEnd)
          begin
            repCount <= repCount + 16'h0001;
            if (repCount + 16'h0001 >= repLimit)
              state <= S_IDLE;
            else
              state <= (startSel == `START_SW) ? S_RUN : S_WAIT;
          end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Conversion request, period check and watchdog
  always @(posedge clk)
  begin
    if (rst)
    begin
      convStart <= 1'b0;
      busy <= 1'b0;
      periodCnt <= 16'h0000;
      wdogCnt <= 18'h00000;
    end
    else
    begin
      convStart <= (state == S_RUN) && tickEdge && !busy && !repeatEnd;
      if ((state == S_RUN) && tickEdge && !busy && !repeatEnd)
        busy <= 1'b1;
      else if (convDone || state != S_RUN)
        busy <= 1'b0;
      if (tickEdge)
        periodCnt <= 16'h0000;
      else if (periodCnt != 16'hFFFF)
        periodCnt <= periodCnt + 16'h0001;
      if (state == S_IDLE || convDone)
        wdogCnt <= 18'h00000;
      else
        wdogCnt <= wdogCnt + 18'h00001;
    end
  end

  // Sample buffer
  always @(posedge clk)
  begin
    if (storeEn)
      mem[wrPtr] <= convData;
  end

  always @(posedge clk)
  begin
    if (rst || cmdMemClr)
    begin
      wrPtr <= {`BUF_AW{1'b0}};
      rdPtr <= {`BUF_AW{1'b0}};
      count <= {`CNT_W{1'b0}};
    end
    else
    begin
      if (storeEn)
        wrPtr <= wrPtr + 1'b1;
      if (fifoPop || (storeEn && full && ringMode))
        rdPtr <= rdPtr + 1'b1;
      count <= nextCount;
    end
  end

  // Status flags; hardware set wins over clear
  always @(posedge clk)
  begin
    if (rst)
      status <= 6'h00;
    else
    begin
      status[`ST_RUN] <= (state != S_IDLE) && !cmdStop && !errStop
        || (state == S_IDLE) && cmdStart && !cmdStop;
      status[`ST_WAIT] <= (state == S_WAIT) && !startMet && !cmdStop && !errStop
        || (state == S_IDLE) && cmdStart && !cmdStop && (startSel != `START_SW)
        || (state == S_RUN) && repeatEnd && !errStop && !cmdStop
          && (repCount + 16'h0001 < repLimit) && (startSel != `START_SW);
      if (countAfter >= thresh && thresh != {`CNT_W{1'b0}})
        status[`ST_THRESH] <= 1'b1;
      else if (cmdMemClr || (!ringMode && countAfter < thresh))
        status[`ST_THRESH] <= 1'b0;
      if (overflowEv)
        status[`ST_OVF] <= 1'b1;
      else if (cmdMemClr)
        status[`ST_OVF] <= 1'b0;
      if (clkErrEv)
        status[`ST_CLKERR] <= 1'b1;
      else if (cmdStatClr)
        status[`ST_CLKERR] <= 1'b0;
      if (convErrEv)
        status[`ST_CONVERR] <= 1'b1;
      else if (cmdStatClr)
        status[`ST_CONVERR] <= 1'b0;
    end
  end

  // Read mux
  always @*
  begin
    next_rdData = 16'h0000;
    case (addr)
      `REG_CTRL: next_rdData = ctrl;
      `REG_STATUS: next_rdData = {10'h000, status};
      `REG_THRESH: next_rdData = {{(16-`CNT_W){1'b0}}, thresh};
      `REG_COUNT: next_rdData = devBuf ? {{(16-`CNT_W){1'b0}}, count} : 16'h0000;
      `REG_REPEAT: next_rdData = repCount;
      `REG_DATA:
        if (ringMode)
          next_rdData = mem[backAddr];
        else if (!empty)
          next_rdData = mem[rdPtr];
      `REG_REPLIM: next_rdData = repLimit;
      `REG_BACK: next_rdData = {{(16-`CNT_W){1'b0}}, backCnt};
      default: next_rdData = 16'h0000;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
      rdData <= 16'h0000;
    else if (rdStb)
      rdData <= next_rdData;
    else
      rdData <= 16'h0000;
  end

endmodule
`default_nettype wire

// File: logic/adc_acq_defines.vh
/*
  Constants for the acquisition control block: command codes, register
  offsets, status bit positions, buffer size and timing counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef ADC_ACQ_DEFINES_VH
`define ADC_ACQ_DEFINES_VH

`define DATA_W 16
`define ADDR_W 4
`define BUF_AW 6
`define BUF_DEPTH 64
`define CNT_W 7
// Sample codes: offset binary, 65536 steps, 32768 is 0 V
`define CODE_STEPS 65536
`define CODE_ZERO_V 16'h8000

// Register word offsets
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_STATUS 4'h2
`define REG_THRESH 4'h3
`define REG_COUNT 4'h4
`define REG_REPEAT 4'h5
`define REG_DATA 4'h6
`define REG_REPLIM 4'h7
`define REG_BACK 4'h8

// Control fields
`define CTRL_RING 0
`define CTRL_START_LO 1
`define CTRL_START_HI 2
`define CTRL_EXTCLK 3
`define CTRL_DEVBUF 4
`define CTRL_RESET 16'h0010

// Start condition encodings
`define START_SW 2'h0
`define START_TRIG 2'h1
`define START_LEVEL 2'h2

// Command bits
`define CMD_START 0
`define CMD_STOP 1
`define CMD_STATCLR 2
`define CMD_MEMCLR 3

// Status bits
`define ST_RUN 0
`define ST_WAIT 1
`define ST_THRESH 2
`define ST_OVF 3
`define ST_CLKERR 4
`define ST_CONVERR 5

// Timing: converter needs 2 us per sample, watchdog 1 ms
`define CONV_MIN_NS 2000
`define CLK_NS 25
`define CONV_MIN_CYC 80
`define WDOG_NS 1000000
`define WDOG_CYC 40000

`endif

// File: bench/converter_model.sv
/* Converter stand-in: answers each start pulse with a done pulse and a
   sample. Assumes the block's clock; samples count up from 0 V. */
`timescale 1ns/100ps
`default_nettype none
module converter_model (
  input wire logic clk, // Clock
  input wire logic slow, // Long conversion
  input wire logic convStart, // Request
  output logic convDone, // Done pulse
  output logic [15:0] convData // Sample
);
  logic [15:0] code = 16'h8000;
  int waitN = 0;
  initial convDone = 1'b0;
  initial convData = 16'h7FFF;
  always @(posedge clk)
  begin
    convDone <= 1'b0;
    // Data not held outside the done cycle
    convData <= ~convData;
    if (convStart)
      waitN <= slow ? 60 : 8;
    else if (waitN > 0)
      waitN <= waitN - 1;
    if (!convStart && waitN == 1)
    begin
      convDone <= 1'b1;
      convData <= code;
      code <= code + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: bench/adc_acq_checker.sv
/* Port assertions for the acquisition block.
   Assumes one clock and synchronous high reset. */
`timescale 1ns/100ps
`default_nettype none
`include "adc_acq_defines.vh"
module adc_acq_checker (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [`ADDR_W-1:0] addr, // Address
  input wire logic [15:0] wrData, // Write data
  input wire logic wrStb, // Write strobe
  input wire logic rdStb, // Read strobe
  input wire logic [15:0] rdData, // Read data
  input wire logic sampleTickPin, // Tick pin
  input wire logic trigPin, // Trigger pin
  input wire logic levelHit, // Level met
  input wire logic convDone, // Done
  input wire logic [`DATA_W-1:0] convData, // Sample
  input wire logic convStart, // Conversion pulse
  input wire logic [5:0] status // Flags
);
  logic ring;
  logic devbuf;
  wire cmd = wrStb && addr == `REG_CMD;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk)
    if (rst)
    begin
      ring <= 1'b0;
      devbuf <= 1'b1;
    end
    else if (wrStb && addr == `REG_CTRL)
    begin
      ring <= wrData[`CTRL_RING];
      devbuf <= wrData[`CTRL_DEVBUF];
    end
  sequence s_halt;
    ##[0:1] !status[`ST_RUN];
  endsequence
  property p_stop;
    cmd && wrData[`CMD_STOP] |=> !status[`ST_RUN];
  endproperty
  a_stop: assert property (p_stop) else $error("run after stop");
  property p_start;
    cmd && wrData == 16'h0001 && status[5:4] == 2'b00 |=> status[`ST_RUN];
  endproperty
  a_start: assert property (p_start) else $error("no run after start");
  property p_rdidle;
    !rdStb |=> rdData == 16'h0000;
  endproperty
  a_rdidle: assert property (p_rdidle) else $error("read data not idle");
  property p_statclr;
    cmd && wrData[`CMD_STATCLR] |=> status[5:4] == 2'b00;
  endproperty
  a_statclr: assert property (p_statclr) else $error("errors kept");
  property p_memclr;
    cmd && wrData[`CMD_MEMCLR] && devbuf && !convDone |=> status[3:2] == 2'b00;
  endproperty
  a_memclr: assert property (p_memclr) else $error("memory flags kept");
  property p_wait;
    convStart |-> !status[`ST_WAIT];
  endproperty
  a_wait: assert property (p_wait) else $error("convert while waiting");
  property p_ovf;
    $rose(status[`ST_OVF]) && !ring |-> s_halt;
  endproperty
  a_ovf: assert property (p_ovf) else $error("run after overflow");
  property p_err;
    $rose(status[`ST_CLKERR]) || $rose(status[`ST_CONVERR]) |-> s_halt;
  endproperty
  a_err: assert property (p_err) else $error("run after error");
endmodule
bind adc_sample_buffer_status adc_acq_checker adc_acq_checker_i (.clk(clk), .rst(rst),
  .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
  .sampleTickPin(sampleTickPin), .trigPin(trigPin), .levelHit(levelHit),
  .convDone(convDone), .convData(convData), .convStart(convStart), .status(status));
`default_nettype wire

// File: bench/testbench.sv
/* Bench for the acquisition block: register driver, tick and trigger
   sources, converter stand-in. Assumes one 40 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
`include "adc_acq_defines.vh"
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wrData = 16'h0000;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic tick = 1'b0;
  logic trig = 1'b0;
  logic lvl = 1'b0;
  logic slow = 1'b0;
  logic tickOn = 1'b0;
  logic [15:0] nw;
  wire [15:0] rdData;
  wire convStart;
  wire convDone;
  wire [15:0] convData;
  wire [5:0] status;
  int n_errors = 0;
  int tests_run = 0;
  int nDone = 0;
  int i;
  logic [3:0] ra [9] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hF};
  logic [15:0] re [9] = '{16'h0010, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  adc_sample_buffer_status #(.WDOG_CYCLES(200)) adc_sample_buffer_status_i (.clk(clk),
    .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .sampleTickPin(tick), .trigPin(trig), .levelHit(lvl), .convDone(convDone),
    .convData(convData), .convStart(convStart), .status(status));
  converter_model converter_model_i (.clk(clk), .slow(slow), .convStart(convStart),
    .convDone(convDone), .convData(convData));
  always #12.5 clk = ~clk;
  // Tick rising edge every 20 cycles
  always
  begin
    repeat (10) @(posedge clk);
    if (tickOn)
      tick <= ~tick;
  end
  always @(posedge clk)
    if (convDone)
      nDone <= nDone + 1;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    chk(rdData, e);
    @(posedge clk);
  endtask
  task automatic st(input logic [5:0] m, input logic [5:0] v);
    #1;
    chk({10'h000, status & m}, {10'h000, v});
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 9; i++)
      rd(ra[i], re[i]);
    wr(`REG_THRESH, 16'h0003);
    wr(`REG_CMD, 16'h0001);
    st(6'h03, 6'h01);
    tickOn <= 1'b1;
    for (i = 0; i < 300 && nDone < 2; i++)
      @(posedge clk);
    rd(`REG_STATUS, 16'h0001);
    for (i = 0; i < 300 && nDone < 3; i++)
      @(posedge clk);
    tickOn <= 1'b0;
    wr(`REG_CMD, 16'h0002);
    st(6'h05, 6'h04);
    rd(`REG_COUNT, 16'h0003);
    rd(`REG_DATA, `CODE_ZERO_V);
    st(6'h04, 6'h00);
    rd(`REG_DATA, 16'h8001);
    rd(`REG_DATA, 16'h8002);
    rd(`REG_DATA, 16'h0000);
    rd(`REG_COUNT, 16'h0000);
    for (i = 1; i < 3; i++)
    begin
      wr(`REG_CTRL, {13'h0000, i[1:0], 1'b0} | 16'h0010);
      wr(`REG_CMD, 16'h0001);
      st(6'h03, 6'h03);
      trig <= (i == 1);
      lvl <= (i == 2);
      repeat (6) @(posedge clk);
      trig <= 1'b0;
      lvl <= 1'b0;
      st(6'h03, 6'h01);
      wr(`REG_CMD, 16'h0002);
    end
    wr(`REG_CTRL, 16'h0010);
    wr(`REG_CMD, 16'h0001);
    repeat (210) @(posedge clk);
    st(6'h21, 6'h20);
    wr(`REG_CMD, 16'h0004);
    st(6'h30, 6'h00);
    slow <= 1'b1;
    tickOn <= 1'b1;
    wr(`REG_CMD, 16'h0001);
    repeat (120) @(posedge clk);
    st(6'h11, 6'h10);
    tickOn <= 1'b0;
    slow <= 1'b0;
    repeat (80) @(posedge clk);
    wr(`REG_CMD, 16'h0004);
    wr(`REG_CMD, 16'h0008);
    wr(`REG_CMD, 16'h0001);
    tickOn <= 1'b1;
    for (i = 0; i < 2000 && !status[3]; i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    st(6'h09, 6'h08);
    tickOn <= 1'b0;
    rd(`REG_COUNT, 16'h0040);
    repeat (30) @(posedge clk);
    wr(`REG_CTRL, 16'h0011);
    wr(`REG_CMD, 16'h0008);
    st(6'h0C, 6'h00);
    rd(`REG_COUNT, 16'h0000);
    wr(`REG_CMD, 16'h0001);
    tickOn <= 1'b1;
    for (i = 0; i < 2000 && !status[3]; i++)
      @(posedge clk);
    repeat (30) @(posedge clk);
    st(6'h0D, 6'h0D);
    tickOn <= 1'b0;
    repeat (40) @(posedge clk);
    wr(`REG_CMD, 16'h0002);
    nw = 16'h7FFF + 16'(nDone);
    wr(`REG_BACK, 16'h0001);
    rd(`REG_DATA, nw);
    rd(`REG_DATA, nw);
    wr(`REG_BACK, 16'h0002);
    rd(`REG_DATA, nw - 16'h0001);
    st(6'h04, 6'h04);
    wr(`REG_REPLIM, 16'h0002);
    wr(`REG_CMD, 16'h0008);
    wr(`REG_CMD, 16'h0001);
    tickOn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 300 && status[0]; i++)
      @(posedge clk);
    tickOn <= 1'b0;
    rd(`REG_REPEAT, 16'h0002);
    wr(`REG_CMD, 16'h0008);
    rd(`REG_REPEAT, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
